/* design/cwu_deadband.sv */
// One dead-band timer: delays the rising edge of a request level.
// Assumes edges on req_i are synchronous to clk_i.
`timescale 1ns/1ns
`include "cwu_defs.svh"
module cwu_deadband import cwu_pkg::*; #(
  parameter int DW = `CWU_DELAY_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic sync_mode_i,
  input wire logic [DW-1:0] count_i,
  output logic out_o
);
  initial begin
    if (DW < 1 || DW > 16) $error("cwu_deadband: DW out of range");
  end
  cwu_dly_e state;
  logic [DW-1:0] cnt;
  logic [DW-1:0] limit;
  // Chain mode approximated in clock steps; two elements per clock
  always_comb begin
    if (sync_mode_i) begin
      limit = count_i;
    end else begin
      limit = DW'(({1'b0, count_i} + DW'(`CWU_ELEM_PER_CLK) - 1'b1) / DW'(`CWU_ELEM_PER_CLK));
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= CWU_IDLE;
      cnt <= '0;
    end else if (!req_i) begin
      state <= CWU_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        CWU_IDLE: begin
          // The first request edge already counts one period, so a limit of n
          // holds the output for exactly n clocks; events are on clk_i, so no skew
          cnt <= DW'(1);
          state <= (limit <= DW'(1)) ? CWU_DONE : CWU_WAIT;
        end
        CWU_WAIT: begin
          if (cnt + 1'b1 >= limit) begin
            state <= CWU_DONE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        CWU_DONE: state <= CWU_DONE;
        default: state <= CWU_IDLE;
      endcase
    end
  end
  // Zero delay passes the request straight through
  assign out_o = req_i && ((state == CWU_DONE) ||
                 (state == CWU_IDLE && limit == '0));
  chk_zero_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (req_i && count_i == '0) |-> out_o) else $error("zero delay not bypassed");
  chk_low_blocks: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !req_i |-> !out_o) else $error("output active without request");
  chk_sync_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($rose(req_i) && sync_mode_i && count_i == DW'(3) && $stable(count_i))
      |-> !out_o ##1 !out_o) else $error("sync dead band too short");
endmodule

/* design/cwu_defs.svh */
// Constants for the complementary waveform unit output stage.
// Included by the package user files; definitions only.
`ifndef CWU_DEFS_SVH
`define CWU_DEFS_SVH
`define CWU_DELAY_W 6
`define CWU_ELEM_NS 5
`define CWU_CLK_NS 10
// Delay elements per clock, rounded down (longest-time figure)
`define CWU_ELEM_PER_CLK (`CWU_CLK_NS / `CWU_ELEM_NS)
`define CWU_MODE_HALF 3'h4
`define CWU_MODE_FULL_FWD 3'h2
`define CWU_MODE_FULL_REV 3'h3
`define CWU_OVR_LOW 2'h0
`define CWU_OVR_HIGH 2'h1
`define CWU_OVR_INACTIVE 2'h2
`define CWU_OVR_TRISTATE 2'h3
`endif

/* design/cwu_output_stage.sv */
// Complementary waveform unit: steering, shutdown, polarity, dead band.
// Assumes rise/fall events and all controls are synchronous to CLK_I.
`timescale 1ns/1ns
`include "cwu_defs.svh"
module cwu_output_stage import cwu_pkg::*; #(
  parameter int DW = `CWU_DELAY_W
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic RISE_EVENT_I,
  input wire logic FALL_EVENT_I,
  input wire logic UNIT_ENABLE_BIT_I,
  input wire logic [2:0] MODE_I,
  input wire logic [3:0] STEERING_SELECT_REG_I,
  input wire logic [3:0] STEER_DATA_I,
  input wire logic SHUTDOWN_I,
  input wire logic [1:0] OVR_AC_I,
  input wire logic [1:0] OVR_BD_I,
  input wire logic [3:0] POLARITY_BITS_I,
  input wire logic RISE_DELAY_TIMING_SELECT_I,
  input wire logic FALL_DELAY_TIMING_SELECT_I,
  input wire logic [DW-1:0] RISE_DELAY_COUNT_REG_I,
  input wire logic [DW-1:0] FALL_DELAY_COUNT_REG_I,
  output cwu_quad_s OUT_O,
  output cwu_quad_s OE_O
);
  initial begin
    if (DW < 1 || DW > 16) $error("cwu_output_stage: DW out of range");
  end

  logic pwm;
  logic enabled_q;
  logic half_mode;
  logic full_mode;
  logic dir_rev;
  logic dir_rev_q;
  logic dir_change;
  logic dir_delay_req;
  logic rise_req;
  logic fall_req;
  logic rise_ok;
  logic fall_ok;
  logic [3:0] act;
  cwu_quad_s pol;
  cwu_quad_s next_out;
  cwu_quad_s next_oe;

  assign pol = POLARITY_BITS_I;
  assign half_mode = (MODE_I == `CWU_MODE_HALF);
  assign full_mode = (MODE_I == `CWU_MODE_FULL_FWD) || (MODE_I == `CWU_MODE_FULL_REV);
  assign dir_rev = (MODE_I == `CWU_MODE_FULL_REV);

  // PWM level: set on rise event, cleared on fall event
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      pwm <= 1'b0;
    end else if (!UNIT_ENABLE_BIT_I) begin
      pwm <= 1'b0;
    end else if (RISE_EVENT_I) begin
      pwm <= 1'b1;
    end else if (FALL_EVENT_I) begin
      pwm <= 1'b0;
    end
  end

  // Enable is delayed one cycle so the first output after enable is the idle state
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      enabled_q <= 1'b0;
    end else begin
      enabled_q <= UNIT_ENABLE_BIT_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      dir_rev_q <= 1'b0;
    end else if (full_mode) begin
      dir_rev_q <= dir_rev;
    end
  end
  assign dir_change = full_mode && (dir_rev != dir_rev_q);

  // Direction-change restart: cleared for the cycle after a change, then set again
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      dir_delay_req <= 1'b0;
    end else if (!full_mode || !enabled_q) begin
      dir_delay_req <= 1'b0;
    end else if (dir_change) begin
      dir_delay_req <= 1'b0;
    end else begin
      dir_delay_req <= 1'b1;
    end
  end

  // Timer requests: in half bridge each follows its phase of the pwm level;
  // in full bridge the timer picked by the direction runs after a change.
  always_comb begin
    rise_req = 1'b1;
    fall_req = 1'b1;
    if (half_mode) begin
      rise_req = pwm;
      fall_req = !pwm;
    end else if (full_mode) begin
      if (dir_rev) begin
        fall_req = dir_delay_req && !dir_change;
      end else begin
        rise_req = dir_delay_req && !dir_change;
      end
    end
  end

  // Two independent timers, each with its own mode select
  cwu_deadband #(.DW(DW)) u_rise (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .req_i(rise_req),
    .sync_mode_i(RISE_DELAY_TIMING_SELECT_I),
    .count_i(RISE_DELAY_COUNT_REG_I),
    .out_o(rise_ok)
  );
  cwu_deadband #(.DW(DW)) u_fall (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .req_i(fall_req),
    .sync_mode_i(FALL_DELAY_TIMING_SELECT_I),
    .count_i(FALL_DELAY_COUNT_REG_I),
    .out_o(fall_ok)
  );

  // Active-high logical drive per output, before polarity
  always_comb begin
    act = 4'h0;
    if (half_mode) begin
      act = {rise_ok, fall_ok, rise_ok, fall_ok};
    end else if (full_mode) begin
      if (dir_rev) begin
        act = {1'b0, pwm && fall_ok, 1'b0, 1'b0};
      end else begin
        act = {1'b0, 1'b0, 1'b0, pwm && rise_ok};
      end
      act[3] = !dir_rev && rise_ok;
      act[1] = dir_rev && fall_ok;
    end else begin
      act = {pwm, !pwm, pwm, !pwm};
    end
  end

  // Pin source selection per output; override levels in three modes skip polarity
  always_comb begin
    logic [3:0] lvl;
    logic [3:0] en;
    logic [3:0] pb;
    logic [1:0] om;
    lvl = 4'h0;
    en = 4'hf;
    pb = {pol.a, pol.b, pol.c, pol.d};
    om = 2'h0;
    for (int i = 0; i < 4; i++) begin
      om = (i == 3 || i == 1) ? OVR_AC_I : OVR_BD_I;
      if (!STEERING_SELECT_REG_I[i]) begin
        lvl[i] = STEER_DATA_I[i] ^ pb[i];
      end else if (SHUTDOWN_I) begin
        unique case (om)
          `CWU_OVR_LOW: lvl[i] = 1'b0;
          `CWU_OVR_HIGH: lvl[i] = 1'b1;
          `CWU_OVR_INACTIVE: lvl[i] = pb[i];
          `CWU_OVR_TRISTATE: begin
            lvl[i] = 1'b0;
            en[i] = 1'b0;
          end
        endcase
      end else if (!enabled_q) begin
        // Primaries (A,C at bits 3,1) inactive, complementaries active
        lvl[i] = ((i == 3 || i == 1) ? 1'b0 : 1'b1) ^ pb[i];
      end else begin
        lvl[i] = act[i] ^ pb[i];
      end
    end
    next_out = lvl;
    next_oe = en;
  end

  // Outputs registered; pin selector outside picks any of the four
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      OUT_O <= '0;
      OE_O <= '0;
    end else begin
      OUT_O <= next_out;
      OE_O <= next_oe;
    end
  end

  chk_idle_levels: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!enabled_q && !SHUTDOWN_I && STEERING_SELECT_REG_I == 4'hf && POLARITY_BITS_I == 4'h0)
      |=> (OUT_O.a == 1'b0 && OUT_O.b == 1'b1 && OUT_O.c == 1'b0 && OUT_O.d == 1'b1))
    else $error("idle levels wrong while disabled");
  chk_steer_data: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!STEERING_SELECT_REG_I[3] && !POLARITY_BITS_I[3]) |=> (OUT_O.a == $past(STEER_DATA_I[3])))
    else $error("static steering data not driven");
  chk_ovr_nopol: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (STEERING_SELECT_REG_I[3] && SHUTDOWN_I && OVR_AC_I == `CWU_OVR_HIGH) |=> OUT_O.a)
    else $error("override high affected by polarity");
  chk_pol_inv: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (STEERING_SELECT_REG_I[2] && !SHUTDOWN_I && !enabled_q && POLARITY_BITS_I[2])
      |=> !OUT_O.b) else $error("polarity not applied");
  chk_half_dead: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (half_mode && $rose(pwm) && RISE_DELAY_COUNT_REG_I != '0)
      |-> !rise_ok) else $error("primary active inside dead band");
  chk_fall_dead: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (half_mode && $fell(pwm) && FALL_DELAY_COUNT_REG_I != '0)
      |-> !fall_ok) else $error("complementary active inside dead band");
  chk_no_dead: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!half_mode && !full_mode) |-> (act == {pwm, !pwm, pwm, !pwm}))
    else $error("dead time applied outside bridge modes");
  chk_rev_dead: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (dir_change && dir_rev && FALL_DELAY_COUNT_REG_I != '0) |=> !fall_ok)
    else $error("reverse change not delayed");
endmodule

/* design/cwu_pkg.sv */
// Types shared by the complementary waveform unit files.
// Assumes cwu_defs.svh sits next to it.
`include "cwu_defs.svh"
package cwu_pkg;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } cwu_quad_s;
  typedef logic [`CWU_DELAY_W-1:0] cwu_delay_t;
  typedef enum logic [1:0] {
    CWU_IDLE = 2'b00,
    CWU_WAIT = 2'b01,
    CWU_DONE = 2'b10
  } cwu_dly_e;
endpackage

/* verification/cwu_switch_model.sv */
// Gate drivers of two half-bridge legs fed by the unit's pins.
// Assumes pins as the output stage drives them; a released pin is pulled low.
`timescale 1ns/1ns
module cwu_switch_model import cwu_pkg::*; (
  input wire logic clk_i,
  input wire cwu_quad_s pin_i,
  input wire cwu_quad_s oe_i,
  output logic [3:0] gate_o,
  output int overlaps_o
);
  // Pull-down: an undriven gate goes off, never keeps its last level
  assign gate_o = pin_i & oe_i;
  initial overlaps_o = 0;
  always @(posedge clk_i) begin
    // Both switches of one leg on shorts the supply
    if ((gate_o[3] & gate_o[2]) | (gate_o[1] & gate_o[0])) begin
      overlaps_o <= overlaps_o + 1;
    end
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for the waveform unit output stage.
// Assumes the switch model is compiled first; inputs move on falling edges.
`timescale 1ns/1ns
`include "cwu_defs.svh"
module tb;
  import cwu_pkg::*;
  logic clk, rstn, rise, fall, en, shd, rsel, fsel;
  logic [2:0] mode;
  logic [3:0] steer, sdata, pol;
  logic [1:0] oac, obd;
  cwu_delay_t rcnt, fcnt;
  cwu_quad_s out, oe;
  logic [3:0] gate;
  int ovl, errors, total_checks;
  cwu_output_stage cwu_output_stage_i (.CLK_I(clk), .RESETN_I(rstn), .RISE_EVENT_I(rise),
    .FALL_EVENT_I(fall), .UNIT_ENABLE_BIT_I(en), .MODE_I(mode), .STEERING_SELECT_REG_I(steer),
    .STEER_DATA_I(sdata), .SHUTDOWN_I(shd), .OVR_AC_I(oac), .OVR_BD_I(obd),
    .POLARITY_BITS_I(pol), .RISE_DELAY_TIMING_SELECT_I(rsel),
    .FALL_DELAY_TIMING_SELECT_I(fsel), .RISE_DELAY_COUNT_REG_I(rcnt),
    .FALL_DELAY_COUNT_REG_I(fcnt), .OUT_O(out), .OE_O(oe));
  cwu_switch_model cwu_switch_model_i (.clk_i(clk), .pin_i(out), .oe_i(oe), .gate_o(gate),
    .overlaps_o(ovl));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for one pin to go high, counting cycles
  task automatic wait_bit(input int idx, output int n);
    n = 0;
    while (out[idx] !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (n >= 40) begin
      errors++;
      test_done();
    end
  endtask
  task automatic ev(input logic r);
    rise = r;
    fall = !r;
    tick(1);
    rise = 1'b0;
    fall = 1'b0;
  endtask
  task automatic lat(input logic r, input int idx, output int n);
    ev(!r);
    tick(20);
    ev(r);
    wait_bit(idx, n);
  endtask
  task automatic dir(input logic [2:0] a, input logic [2:0] b, input int idx, output int n);
    mode = a;
    tick(20);
    mode = b;
    wait_bit(idx, n);
  endtask
  task automatic t_idle;
    tick(3);
    check({4'h0, out}, 8'h05, "idle");
    check({4'h0, oe}, 8'h0f, "drive");
    pol = 4'hf;
    tick(2);
    check({4'h0, out}, 8'h0a, "idle pol");
    pol = 4'h0;
    tick(2);
    en = 1'b1;
    @(posedge clk);
    #1;
    check({4'h0, out}, 8'h05, "enable");
    tick(1);
    steer = 4'h0;
    sdata = 4'h9;
    tick(3);
    check({4'h0, out}, 8'h09, "static");
    pol = 4'h6;
    tick(3);
    check({4'h0, out}, 8'h0f, "static pol");
    $display("done idle and static");
  endtask
  task automatic t_override;
    logic [3:0] lv [4] = '{4'h0, 4'hf, 4'ha, 4'h0};
    steer = 4'hf;
    shd = 1'b1;
    pol = 4'ha;
    for (int m = 0; m < 4; m++) begin
      oac = m[1:0];
      obd = m[1:0];
      tick(3);
      if (m < 3) check({4'h0, out}, {4'h0, lv[m]}, "ovr");
      check({4'h0, oe}, (m == 3) ? 8'h00 : 8'h0f, "ovr oe");
    end
    shd = 1'b0;
    pol = 4'h0;
    $display("done override");
  endtask
  task automatic t_dead;
    int l0, l, f0, o0;
    o0 = ovl;
    lat(1'b1, 3, l0);
    check({4'h0, out}, 8'h0a, "pwm");
    pol = 4'hf;
    tick(3);
    check({4'h0, out}, 8'h05, "pwm pol");
    pol = 4'h0;
    rcnt = 6'h04;
    lat(1'b1, 3, l);
    check(8'(l), 8'(l0 + 4), "cnt rise");
    rsel = 1'b0;
    lat(1'b1, 3, l);
    check(8'(l), 8'(l0 + 2), "chain rise");
    lat(1'b0, 2, f0);
    fcnt = 6'h03;
    lat(1'b0, 2, l);
    check(8'(l), 8'(f0 + 3), "cnt fall");
    check(8'(ovl - o0), 8'h00, "overlap");
    mode = 3'h0;
    rsel = 1'b1;
    rcnt = 6'h06;
    lat(1'b1, 3, l);
    check(8'(l), 8'(l0), "no dead time");
    $display("done dead band");
  endtask
  task automatic t_full;
    int d0, d;
    rcnt = 6'h00;
    fcnt = 6'h00;
    dir(`CWU_MODE_FULL_FWD, `CWU_MODE_FULL_REV, 1, d0);
    fcnt = 6'h05;
    dir(`CWU_MODE_FULL_FWD, `CWU_MODE_FULL_REV, 1, d);
    check(8'(d), 8'(d0 + 5), "fwd to rev");
    dir(`CWU_MODE_FULL_REV, `CWU_MODE_FULL_FWD, 3, d0);
    rcnt = 6'h02;
    dir(`CWU_MODE_FULL_REV, `CWU_MODE_FULL_FWD, 3, d);
    check(8'(d), 8'(d0 + 2), "rev to fwd");
    $display("done full bridge");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, rise, fall, en, shd} = 5'h0;
    {rsel, fsel} = 2'h3;
    mode = `CWU_MODE_HALF;
    steer = 4'hf;
    {sdata, pol, oac, obd} = 12'h0;
    rcnt = 6'h00;
    fcnt = 6'h00;
    errors = 0;
    total_checks = 0;
    tick(4);
    check({out, oe}, 8'h00, "reset");
    rstn = 1'b1;
    t_idle();
    t_override();
    t_dead();
    t_full();
    test_done();
  end
endmodule
